// >>> rtl/duh_map.svh
// Purpose: Register offsets, field positions, reset values and counts of the dual UART.
// Assumes: Included by bare name.
// Notes: Definitions only.
`ifndef DUH_MAP_SVH
`define DUH_MAP_SVH

// Register select decode
`define DUH_SEL_CHAN_BIT 3
`define DUH_REG_MODE 3'h0
`define DUH_REG_STATUS 3'h1
`define DUH_REG_DATA 3'h3
`define DUH_REG_INPORT 4'h4
`define DUH_REG_CONFIG 4'h5
`define DUH_REG_DIV 4'h6
`define DUH_REG_VECTOR 4'hC

// Field positions
`define DUH_MODE_W 6
`define DUH_CFG_ZMODE 0
`define DUH_ST_RXRDY 0
`define DUH_ST_TXRDY 1
`define DUH_ST_TXEMPTY 2
`define DUH_ST_OVR 3
`define DUH_ST_FERR 4
`define DUH_ST_CTS 5

// Reset values
`define DUH_DIV_RST 8'h35
`define DUH_VEC_RST 8'h0F
`define DUH_PINS_RST 23'h7000EF

// Bit timing counts and transmit FIFO size
`define DUH_MID_SAMPLE 4'h7
`define DUH_LAST_SUB 4'hF
`define DUH_LAST_BIT 3'h7
`define DUH_FIFO_W 8
`define DUH_FIFO_D 16

`endif

// >>> rtl/duh_pkg.sv
// Purpose: Types shared by the dual UART files.
// Assumes: Nothing.
// Notes: Field widths follow duh_map.svh.
package duh_pkg;
	typedef enum logic [1:0] {
		DUH_RX_IDLE = 2'b00,
		DUH_RX_START = 2'b01,
		DUH_RX_DATA = 2'b10,
		DUH_RX_STOP = 2'b11
	} duh_rx_st_t;

	typedef enum logic [1:0] {
		DUH_TX_IDLE = 2'b00,
		DUH_TX_DATA = 2'b01,
		DUH_TX_STOP = 2'b10
	} duh_tx_st_t;

	typedef struct packed {
		logic cts_en;
		logic tx_ext;
		logic rx_ext;
		logic loop;
		logic tx_en;
		logic rx_en;
	} duh_mode_t;

	typedef struct packed {
		duh_rx_st_t rx_st;
		logic [3:0] rx_sub;
		logic [2:0] rx_bit;
		logic [7:0] rx_shift;
		logic [7:0] rx_hold;
		logic rx_rdy;
		logic rx_ovr;
		logic rx_ferr;
		duh_tx_st_t tx_st;
		logic [2:0] tx_bit;
		logic [7:0] tx_shift;
		logic tx_line;
	} duh_chan_t;

	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic [3:0] sel;
		logic [7:0] data;
		logic rxd_a;
		logic rxd_b;
		logic ip3;
		logic rxc_b;
		logic txc_b;
		logic ip0;
		logic ip1;
		logic interrupt_ack_cycle_n;
	} duh_pins_t;

	typedef struct packed {
		duh_chan_t [1:0] ch;
		duh_mode_t [1:0] mode;
		logic [3:0] tx_sub;
		logic [7:0] div;
		logic [7:0] div_cnt;
		logic zmode;
		logic [7:0] vector;
		duh_pins_t prev;
		logic wr_act;
		logic [3:0] wr_sel;
		logic [7:0] wr_data;
		logic rd_act;
		logic [3:0] rd_sel;
		logic [7:0] rd_data;
		logic rd_oe;
		logic [1:0] ser_out;
	} duh_state_t;
endpackage

// >>> rtl/duh_sync.sv
// Purpose: Two-flop synchroniser for a bundle of asynchronous pins.
// Assumes: Each bit is a level; no multi-bit coherence is promised.
// Notes: First stage is read only by the second.
`timescale 1ns/1ps
module duh_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Pins
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} duh_sync_state_t;

	duh_sync_state_t q;
	duh_sync_state_t d;

	always_comb begin
		d = q;
		d.s1 = i_async;
		d.s2 = q.s1;
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			q <= {RST_VAL, RST_VAL};
		end else begin
			q <= d;
		end
	end

	assign o_sync = q.s2;
endmodule

// >>> rtl/duh_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides.
// Assumes: D is at least 2.
// Notes: Simultaneous push and pop allowed when neither empty nor full.
`timescale 1ns/1ps
module duh_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Fill side
	input wire logic i_push_valid,
	output logic o_push_ready,
	input wire logic [W-1:0] i_push_data,
	// Drain side
	output logic o_pop_valid,
	input wire logic i_pop_ready,
	output logic [W-1:0] o_pop_data
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL = (AW + 1)'(D);
	localparam logic [AW-1:0] LAST = AW'(D - 1);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] count;
	} duh_fifo_state_t;

	duh_fifo_state_t q;
	duh_fifo_state_t d;

	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
		nxt = (p == LAST) ? '0 : p + 1'b1;
	endfunction

	assign o_push_ready = (q.count != FULL);
	assign o_pop_valid = (q.count != '0);
	assign o_pop_data = q.mem[q.rd_ptr];

	always_comb begin
		logic push;
		logic pop;
		push = i_push_valid && o_push_ready;
		pop = i_pop_ready && o_pop_valid;
		d = q;
		if (push) begin
			d.mem[q.wr_ptr] = i_push_data;
			d.wr_ptr = nxt(q.wr_ptr);
		end
		if (pop) begin
			d.rd_ptr = nxt(q.rd_ptr);
		end
		if (push && !pop) begin
			d.count = q.count + 1'b1;
		end else if (pop && !push) begin
			d.count = q.count - 1'b1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule

// >>> rtl/duh_top.sv
// Purpose: Host register port and serial pins of a two-channel asynchronous UART.
// Assumes: i_mclk at 100 MHz; all pins asynchronous to it.
// Notes: Register map, divider and vector register are local to this block.
`timescale 1ns/1ps
`include "duh_map.svh"
module duh_top (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Host bus
	input wire logic [3:0] i_reg_sel,
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic i_interrupt_ack_cycle_n,
	input wire logic [7:0] i_data,
	output logic [7:0] o_data,
	output logic o_data_oe,
	// Channel A serial
	input wire logic i_serial_in_chan_a,
	output logic o_serial_out_chan_a,
	// Channel B serial
	input wire logic i_serial_in_chan_b,
	output logic o_serial_out_chan_b,
	input wire logic i_ext_rx_clock_chan_b,
	input wire logic i_ext_tx_clock_chan_b,
	// General-purpose inputs
	input wire logic i_gp_input_zero,
	input wire logic i_gp_input_one,
	input wire logic i_gp_input_three
);
	duh_pkg::duh_state_t q;
	duh_pkg::duh_state_t d;
	duh_pkg::duh_pins_t p;
	logic [22:0] pins_raw;
	logic [22:0] pins_sync;
	logic tick;
	logic wr_commit;
	logic [1:0] push_valid;
	logic [1:0] push_ready;
	logic [1:0] pop_valid;
	logic [1:0] pop_ready;
	logic [1:0][7:0] pop_data;

	function automatic logic is_chan_reg(input logic [3:0] sel);
		is_chan_reg = (sel[2:0] == `DUH_REG_MODE) || (sel[2:0] == `DUH_REG_STATUS) ||
			(sel[2:0] == `DUH_REG_DATA);
	endfunction

	function automatic logic [7:0] rd_mux(
		input duh_pkg::duh_state_t s,
		input duh_pkg::duh_pins_t pin,
		input logic [3:0] sel,
		input logic [1:0] tx_rdy,
		input logic [1:0] tx_any
	);
		logic c;
		logic [7:0] r;
		c = sel[`DUH_SEL_CHAN_BIT];
		r = 8'h00;
		if (is_chan_reg(sel)) begin
			case (sel[2:0])
				`DUH_REG_MODE: r = {2'h0, s.mode[c]};
				`DUH_REG_STATUS: begin
					r[`DUH_ST_RXRDY] = s.ch[c].rx_rdy;
					r[`DUH_ST_TXRDY] = tx_rdy[c];
					r[`DUH_ST_TXEMPTY] = !tx_any[c] && (s.ch[c].tx_st == duh_pkg::DUH_TX_IDLE);
					r[`DUH_ST_OVR] = s.ch[c].rx_ovr;
					r[`DUH_ST_FERR] = s.ch[c].rx_ferr;
					r[`DUH_ST_CTS] = c ? !pin.ip1 : !pin.ip0;
				end
				`DUH_REG_DATA: r = s.ch[c].rx_hold;
				default: r = 8'h00;
			endcase
		end else begin
			case (sel)
				`DUH_REG_INPORT: r = {4'h0, pin.ip3, 1'b0, pin.ip1, pin.ip0};
				`DUH_REG_CONFIG: r = {7'h00, s.zmode};
				`DUH_REG_DIV: r = s.div;
				`DUH_REG_VECTOR: r = s.vector;
				default: r = 8'h00;
			endcase
		end
		rd_mux = r;
	endfunction

	// Every pin is asynchronous to i_mclk
	assign pins_raw = {i_cs_n, i_rd_n, i_wr_n, i_reg_sel, i_data,
		i_serial_in_chan_a, i_serial_in_chan_b, i_gp_input_three,
		i_ext_rx_clock_chan_b, i_ext_tx_clock_chan_b,
		i_gp_input_zero, i_gp_input_one, i_interrupt_ack_cycle_n};

	duh_sync #(
		.W(23),
		.RST_VAL(`DUH_PINS_RST)
	) u_sync (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_async(pins_raw),
		.o_sync(pins_sync)
	);

	assign p = duh_pkg::duh_pins_t'(pins_sync);
	assign tick = (q.div_cnt == q.div);
	assign wr_commit = q.wr_act && p.wr_n && !q.prev.wr_n;

	for (genvar g = 0; g < 2; g++) begin : g_chan
		assign push_valid[g] = wr_commit && is_chan_reg(q.wr_sel) &&
			(q.wr_sel[2:0] == `DUH_REG_DATA) &&
			(q.wr_sel[`DUH_SEL_CHAN_BIT] == 1'(g));
		duh_fifo #(
			.W(`DUH_FIFO_W),
			.D(`DUH_FIFO_D)
		) u_tx_fifo (
			.i_mclk(i_mclk),
			.i_rst(i_rst),
			.i_push_valid(push_valid[g]),
			.o_push_ready(push_ready[g]),
			.i_push_data(q.wr_data),
			.o_pop_valid(pop_valid[g]),
			.i_pop_ready(pop_ready[g]),
			.o_pop_data(pop_data[g])
		);
	end

	always_comb begin
		logic c;
		logic rd_now;
		logic interrupt_ack_cycle;
		logic rxd;
		logic rx_ext;
		logic rise;
		logic tx_ext;
		logic fall;
		logic bit_ev;
		logic tx_ev;
		logic cts_ok;
		c = 1'b0;
		rd_now = 1'b0;
		interrupt_ack_cycle = 1'b0;
		rxd = 1'b1;
		rx_ext = 1'b0;
		rise = 1'b0;
		tx_ext = 1'b0;
		fall = 1'b0;
		bit_ev = 1'b0;
		tx_ev = 1'b0;
		cts_ok = 1'b0;
		pop_ready = 2'b00;
		d = q;
		d.prev = p;
		d.div_cnt = tick ? 8'h00 : q.div_cnt + 8'h01;
		if (tick) begin
			d.tx_sub = q.tx_sub + 4'h1;
		end

		// Write latch while both strobes low, commit on strobe release
		if (!p.cs_n && !p.wr_n) begin
			d.wr_act = 1'b1;
			d.wr_sel = p.sel;
			d.wr_data = p.data;
		end
		if (wr_commit) begin
			d.wr_act = 1'b0;
			c = q.wr_sel[`DUH_SEL_CHAN_BIT];
			if (is_chan_reg(q.wr_sel)) begin
				case (q.wr_sel[2:0])
					`DUH_REG_MODE: d.mode[c] = duh_pkg::duh_mode_t'(q.wr_data[`DUH_MODE_W-1:0]);
					`DUH_REG_STATUS: begin
						d.ch[c].rx_ovr = 1'b0;
						d.ch[c].rx_ferr = 1'b0;
					end
					default: ;
				endcase
			end else begin
				case (q.wr_sel)
					`DUH_REG_CONFIG: d.zmode = q.wr_data[`DUH_CFG_ZMODE];
					`DUH_REG_DIV: d.div = q.wr_data;
					`DUH_REG_VECTOR: d.vector = q.wr_data;
					default: ;
				endcase
			end
		end

		// Read drive and acknowledge vector
		rd_now = !p.cs_n && !p.rd_n;
		interrupt_ack_cycle = q.zmode && !p.interrupt_ack_cycle_n;
		d.rd_act = rd_now;
		d.rd_oe = rd_now || interrupt_ack_cycle;
		if (rd_now) begin
			d.rd_sel = p.sel;
			d.rd_data = rd_mux(q, p, p.sel, push_ready, pop_valid);
		end else if (interrupt_ack_cycle) begin
			d.rd_data = q.vector;
		end
		if (q.rd_act && !rd_now && is_chan_reg(q.rd_sel) &&
			(q.rd_sel[2:0] == `DUH_REG_DATA)) begin
			d.ch[q.rd_sel[`DUH_SEL_CHAN_BIT]].rx_rdy = 1'b0;
		end

		for (int k = 0; k < 2; k++) begin
			// Clock routing per channel and bus mode
			if (k == 0) begin
				rx_ext = q.mode[0].rx_ext && q.zmode;
				rise = p.ip3 && !q.prev.ip3;
				tx_ext = q.mode[0].tx_ext && !q.zmode;
				fall = !p.ip3 && q.prev.ip3;
				rxd = p.rxd_a;
				cts_ok = !q.mode[0].cts_en || !p.ip0;
			end else begin
				rx_ext = q.mode[1].rx_ext;
				rise = p.rxc_b && !q.prev.rxc_b;
				tx_ext = q.mode[1].tx_ext;
				fall = !p.txc_b && q.prev.txc_b;
				rxd = p.rxd_b;
				cts_ok = !q.mode[1].cts_en || !p.ip1;
			end
			if (q.mode[k].loop) begin
				rxd = q.ch[k].tx_line;
			end

			// Receiver
			if (!rx_ext && tick && (q.ch[k].rx_st != duh_pkg::DUH_RX_IDLE)) begin
				d.ch[k].rx_sub = q.ch[k].rx_sub + 4'h1;
			end
			bit_ev = rx_ext ? rise : (tick && (q.ch[k].rx_sub == `DUH_LAST_SUB));
			case (q.ch[k].rx_st)
				duh_pkg::DUH_RX_IDLE: begin
					if (q.mode[k].rx_en && !rxd && (rx_ext ? rise : tick)) begin
						d.ch[k].rx_sub = 4'h0;
						d.ch[k].rx_bit = 3'h0;
						d.ch[k].rx_st = rx_ext ? duh_pkg::DUH_RX_DATA : duh_pkg::DUH_RX_START;
					end
				end
				duh_pkg::DUH_RX_START: begin
					if (tick && (q.ch[k].rx_sub == `DUH_MID_SAMPLE)) begin
						d.ch[k].rx_sub = 4'h0;
						d.ch[k].rx_st = rxd ? duh_pkg::DUH_RX_IDLE : duh_pkg::DUH_RX_DATA;
					end
				end
				duh_pkg::DUH_RX_DATA: begin
					if (bit_ev) begin
						d.ch[k].rx_shift = {rxd, q.ch[k].rx_shift[7:1]};
						d.ch[k].rx_bit = q.ch[k].rx_bit + 3'h1;
						if (q.ch[k].rx_bit == `DUH_LAST_BIT) begin
							d.ch[k].rx_st = duh_pkg::DUH_RX_STOP;
						end
					end
				end
				duh_pkg::DUH_RX_STOP: begin
					if (bit_ev) begin
						d.ch[k].rx_hold = q.ch[k].rx_shift;
						d.ch[k].rx_rdy = 1'b1;
						d.ch[k].rx_ferr = !rxd;
						if (q.ch[k].rx_rdy) begin
							d.ch[k].rx_ovr = 1'b1;
						end
						d.ch[k].rx_st = duh_pkg::DUH_RX_IDLE;
					end
				end
				default: d.ch[k].rx_st = duh_pkg::DUH_RX_IDLE;
			endcase
			if (!q.mode[k].rx_en) begin
				d.ch[k].rx_st = duh_pkg::DUH_RX_IDLE;
			end

			// Transmitter
			tx_ev = tx_ext ? fall : (tick && (q.tx_sub == `DUH_LAST_SUB));
			case (q.ch[k].tx_st)
				duh_pkg::DUH_TX_IDLE: begin
					d.ch[k].tx_line = 1'b1;
					if (tx_ev && q.mode[k].tx_en && pop_valid[k] && cts_ok) begin
						pop_ready[k] = 1'b1;
						d.ch[k].tx_shift = pop_data[k];
						d.ch[k].tx_bit = 3'h0;
						d.ch[k].tx_line = 1'b0;
						d.ch[k].tx_st = duh_pkg::DUH_TX_DATA;
					end
				end
				duh_pkg::DUH_TX_DATA: begin
					if (tx_ev) begin
						d.ch[k].tx_line = q.ch[k].tx_shift[0];
						d.ch[k].tx_shift = {1'b0, q.ch[k].tx_shift[7:1]};
						d.ch[k].tx_bit = q.ch[k].tx_bit + 3'h1;
						if (q.ch[k].tx_bit == `DUH_LAST_BIT) begin
							d.ch[k].tx_st = duh_pkg::DUH_TX_STOP;
						end
					end
				end
				duh_pkg::DUH_TX_STOP: begin
					if (tx_ev) begin
						d.ch[k].tx_line = 1'b1;
						d.ch[k].tx_st = duh_pkg::DUH_TX_IDLE;
					end
				end
				default: d.ch[k].tx_st = duh_pkg::DUH_TX_IDLE;
			endcase
			if (!d.mode[k].tx_en) begin
				d.ch[k].tx_line = 1'b1;
				d.ch[k].tx_st = duh_pkg::DUH_TX_IDLE;
			end
			d.ser_out[k] = d.mode[k].loop ? 1'b1 : d.ch[k].tx_line;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			q <= '0;
			q.div <= `DUH_DIV_RST;
			q.vector <= `DUH_VEC_RST;
			q.prev <= duh_pkg::duh_pins_t'(`DUH_PINS_RST);
			q.ch[0].tx_line <= 1'b1;
			q.ch[1].tx_line <= 1'b1;
			q.ser_out <= 2'h3;
		end else begin
			q <= d;
		end
	end

	assign o_data = q.rd_data;
	assign o_data_oe = q.rd_oe;
	assign o_serial_out_chan_a = q.ser_out[0];
	assign o_serial_out_chan_b = q.ser_out[1];
endmodule

// >>> tb/duh_top_assertions.sv
// Purpose: Port checks of the dual UART host bus and serial outputs.
// Assumes: Only duh_top ports are visible.
// Notes: Bound to duh_top at the foot.
`timescale 1ns/1ps
module duh_chk (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Host bus
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic i_interrupt_ack_cycle_n,
	input wire logic [7:0] o_data,
	input wire logic o_data_oe,
	// Serial outputs
	input wire logic o_serial_out_chan_a,
	input wire logic o_serial_out_chan_b
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);
	logic rd_req;
	assign rd_req = !i_cs_n && !i_rd_n;
	sequence s_rd;
		(rd_req && i_wr_n)[*4];
	endsequence
	sequence s_wr;
		(!i_cs_n && !i_wr_n && i_rd_n && i_interrupt_ack_cycle_n)[*4];
	endsequence
	sequence s_idle;
		(i_cs_n && i_interrupt_ack_cycle_n)[*4];
	endsequence
	a_read_drives: assert property (s_rd |-> o_data_oe)
		else $error("bus not driven in read");
	a_write_floats: assert property (s_wr |-> !o_data_oe)
		else $error("bus driven in write");
	a_bus_floats: assert property (s_idle |-> !o_data_oe)
		else $error("bus driven while deselected");
	a_strobe_sync: assert property ($fell(i_rd_n) && !i_cs_n && !o_data_oe |=> (!o_data_oe)[*2])
		else $error("read answered too early");
	a_oe_cause: assert property ($rose(o_data_oe) |->
		$past(rd_req, 2) || $past(!i_interrupt_ack_cycle_n, 2))
		else $error("bus driven without cause");
	a_oe_release: assert property ($rose(i_cs_n) && i_interrupt_ack_cycle_n |-> ##[1:4] !o_data_oe)
		else $error("bus not released");
	a_reset_idle: assert property ($fell(i_rst) |->
		o_serial_out_chan_a && o_serial_out_chan_b && !o_data_oe && o_data == 8'h00)
		else $error("outputs not idle after reset");
	a_tx_b_steady: assert property ($changed(o_serial_out_chan_b) |=> $stable(o_serial_out_chan_b)[*3])
		else $error("channel B line glitch");
	a_tx_a_steady: assert property ($changed(o_serial_out_chan_a) |=> $stable(o_serial_out_chan_a)[*3])
		else $error("channel A line glitch");
endmodule
bind duh_top duh_chk u_chk (.i_mclk, .i_rst, .i_cs_n, .i_rd_n, .i_wr_n, .i_interrupt_ack_cycle_n,
	.o_data, .o_data_oe, .o_serial_out_chan_a, .o_serial_out_chan_b);

// >>> tb/duh_term.sv
// Purpose: Far-end serial terminal with 1x receive and transmit clocks.
// Assumes: Clocks stand still outside frames.
// Notes: Data line idles high like a pulled-up line.
`timescale 1ns/1ps
module duh_term #(
	parameter int HC = 20
) (
	// Clock
	input wire logic i_mclk,
	// Serial link
	output logic o_rxd,
	output logic o_rxc,
	output logic o_txc,
	input wire logic i_txd
);
	initial begin
		o_rxd = 1'b1;
		o_rxc = 1'b0;
		o_txc = 1'b1;
	end
	// Start, data LSB first, stop
	task automatic send(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			o_rxd <= fr[i];
			repeat (HC) @(posedge i_mclk);
			o_rxc <= 1'b1;
			repeat (HC) @(posedge i_mclk);
			o_rxc <= 1'b0;
		end
	endtask
	// Device shifts on falls; sample just before each rise
	task automatic recv(output logic [9:0] fr);
		for (int i = 0; i < 10; i++) begin
			o_txc <= 1'b0;
			repeat (HC) @(posedge i_mclk);
			fr[i] = i_txd;
			o_txc <= 1'b1;
			repeat (HC) @(posedge i_mclk);
		end
	endtask
endmodule

// >>> tb/duh_top_tb.sv
// Purpose: Self-checking bench of the dual UART host port and serial pins.
// Assumes: duh_term models the far serial ends.
// Notes: Channel B and channel A transmit run on 1x external clocks.
`timescale 1ns/1ps
module duh_top_tb;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic [3:0] i_reg_sel = 4'h0;
	logic i_cs_n = 1'b1;
	logic i_rd_n = 1'b1;
	logic i_wr_n = 1'b1;
	logic i_interrupt_ack_cycle_n = 1'b1;
	logic [7:0] host_d = 8'h00;
	logic i_gp_input_zero = 1'b1;
	logic i_gp_input_one = 1'b1;
	logic [7:0] o_data;
	logic o_data_oe;
	logic o_serial_out_chan_a;
	logic o_serial_out_chan_b;
	wire logic i_serial_in_chan_b;
	wire logic i_ext_rx_clock_chan_b;
	wire logic i_ext_tx_clock_chan_b;
	wire logic i_serial_in_chan_a;
	wire logic rxc_a;
	wire logic txc_a;
	logic a_rx_clk = 1'b0;
	// Input three carries the channel A receive clock when a_rx_clk is set
	wire logic i_gp_input_three = a_rx_clk ? rxc_a : txc_a;
	// Bus wire: device when enabled, else host
	wire logic [7:0] i_data = o_data_oe ? o_data : host_d;
	int fails = 0;
	int checked = 0;
	logic [9:0] f;
	logic [7:0] d;
	always #5 i_mclk = ~i_mclk;
	duh_top u_dut (.i_mclk, .i_rst, .i_reg_sel, .i_cs_n, .i_rd_n, .i_wr_n,
		.i_interrupt_ack_cycle_n, .i_data, .o_data, .o_data_oe,
		.i_serial_in_chan_a, .o_serial_out_chan_a, .i_serial_in_chan_b,
		.o_serial_out_chan_b, .i_ext_rx_clock_chan_b, .i_ext_tx_clock_chan_b,
		.i_gp_input_zero, .i_gp_input_one, .i_gp_input_three);
	duh_term u_term_b (.i_mclk, .o_rxd(i_serial_in_chan_b), .o_rxc(i_ext_rx_clock_chan_b),
		.o_txc(i_ext_tx_clock_chan_b), .i_txd(o_serial_out_chan_b));
	duh_term u_term_a (.i_mclk, .o_rxd(i_serial_in_chan_a), .o_rxc(rxc_a), .o_txc(txc_a),
		.i_txd(o_serial_out_chan_a));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	task automatic wait_oe(input logic lvl);
		int n;
		n = 0;
		do begin
			@(negedge i_mclk);
			n++;
		end while (o_data_oe !== lvl && n < 9);
		if (o_data_oe !== lvl) begin
			fails++;
			end_of_test();
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge i_mclk);
		i_cs_n <= 1'b0;
		i_wr_n <= 1'b0;
		i_reg_sel <= a;
		host_d <= v;
		tick(4);
		i_wr_n <= 1'b1;
		tick(4);
		i_cs_n <= 1'b1;
		host_d <= ~v;
		tick(4);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge i_mclk);
		i_cs_n <= 1'b0;
		i_rd_n <= 1'b0;
		i_reg_sel <= a;
		wait_oe(1'b1);
		@(negedge i_mclk);
		v = o_data;
		@(posedge i_mclk);
		i_rd_n <= 1'b1;
		tick(4);
		i_cs_n <= 1'b1;
		tick(4);
	endtask
	task automatic t_reset();
		chk({7'h00, o_data_oe}, 8'h00);
		chk({6'h00, o_serial_out_chan_a, o_serial_out_chan_b}, 8'h03);
		rd(4'h6, d);
		chk(d, 8'h35);
		rd(4'hC, d);
		chk(d, 8'h0F);
		rd(4'h7, d);
		chk(d, 8'h00);
		rd(4'h4, d);
		chk(d, 8'h0B);
	endtask
	task automatic t_regs();
		wr(4'h0, 8'h24);
		rd(4'h0, d);
		chk(d, 8'h24);
		wr(4'h6, 8'h01);
		rd(4'h6, d);
		chk(d, 8'h01);
		wr(4'h4, 8'hFF);
		rd(4'h4, d);
		chk(d, 8'h0B);
	endtask
	task automatic t_txa();
		i_gp_input_zero <= 1'b0;
		wr(4'h0, 8'h32);
		wr(4'h3, 8'h3C);
		u_term_a.recv(f);
		chk(f[8:1], 8'h3C);
		chk({6'h00, f[9], f[0]}, 8'h02);
	endtask
	task automatic t_txb();
		wr(4'h8, 8'h32);
		wr(4'hB, 8'hA6);
		wr(4'hB, 8'h51);
		u_term_b.recv(f);
		chk(f[7:0], 8'hFF);
		i_gp_input_one <= 1'b0;
		tick(4);
		u_term_b.recv(f);
		chk(f[8:1], 8'hA6);
		u_term_b.recv(f);
		chk(f[8:1], 8'h51);
		chk({6'h00, f[9], f[0]}, 8'h02);
	endtask
	task automatic t_rxb();
		wr(4'h8, 8'h09);
		u_term_b.send(8'hC3);
		tick(4);
		rd(4'h9, d);
		chk({7'h00, d[0]}, 8'h01);
		rd(4'hB, d);
		chk(d, 8'hC3);
		rd(4'h9, d);
		chk({7'h00, d[0]}, 8'h00);
	endtask
	task automatic t_loop();
		int lows;
		lows = 0;
		wr(4'h0, 8'h07);
		wr(4'h3, 8'h5A);
		repeat (500) begin
			@(negedge i_mclk);
			lows += int'(!o_serial_out_chan_a);
		end
		chk({7'h00, lows != 0}, 8'h00);
		rd(4'h3, d);
		chk(d, 8'h5A);
	endtask
	task automatic t_interrupt_ack_cycle();
		wr(4'h5, 8'h01);
		i_interrupt_ack_cycle_n <= 1'b0;
		wait_oe(1'b1);
		chk(o_data, 8'h0F);
		@(posedge i_mclk);
		i_interrupt_ack_cycle_n <= 1'b1;
		wait_oe(1'b0);
		wr(4'h5, 8'h00);
		i_interrupt_ack_cycle_n <= 1'b0;
		tick(6);
		@(negedge i_mclk);
		chk({7'h00, o_data_oe}, 8'h00);
		@(posedge i_mclk);
		i_interrupt_ack_cycle_n <= 1'b1;
	endtask
	task automatic t_rxa();
		wr(4'h5, 8'h01);
		a_rx_clk <= 1'b1;
		wr(4'h0, 8'h09);
		u_term_a.send(8'h96);
		tick(4);
		rd(4'h3, d);
		chk(d, 8'h96);
	endtask
	initial begin
		tick(8);
		i_rst <= 1'b0;
		tick(2);
		t_reset();
		t_regs();
		t_txa();
		t_txb();
		t_rxb();
		t_loop();
		t_interrupt_ack_cycle();
		t_rxa();
		end_of_test();
	end
	initial begin
		tick(50000);
		fails++;
		end_of_test();
	end
endmodule
